// File: design/tmr_top.sv
// Temperature result, offset and limit registers for three channels
//
// Notes on behaviour
// - Results are 10 bits; two low bits separate
// - Extended range codes with offset of 64
// - Signed encoding is twos complement, -128 to 127
// - Per-channel signed offset added before storing
// - Offset is 8 bits, half degree per count
// - Offsets reset to zero
// - Compatibility bit selects twos complement storage
// - Compat limits below -63 clamp to -63
// - Fault code 0x80 compat, 0x00 extended
// - Three read-only result bytes reset 0x01
// - Low bits packed remote2, local, remote1
// - Each channel compared with own limits
// - Six limits, low 0x01, high 0x7F
// - Result bytes readable anytime; a read while frozen counts toward release
// - Low-bits read freezes results until all read
// - High is strictly greater, low less-or-equal
`timescale 1ns/100ps
module tmr_top
  import tmr_pkg::*;
(
  input wire logic core_clk, // System clock, 20 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
  input wire logic meas_valid, // New measurement, one cycle
  input wire logic [1:0] meas_chan, // Channel of the measurement
  input wire logic signed [11:0] meas_temp, // Raw temperature, quarter degrees
  input wire logic meas_fault, // Diode fault on this measurement
  output logic [2:0] temp_high_status, // Result above high limit, per channel
  output logic [2:0] temp_low_status, // Result at or below low limit, per channel
  output logic alert_req, // Any channel out of limits
  output logic result_frozen, // Result registers held for a 10-bit read
  output logic compat_mode // Twos complement storage active
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam int NCH = 3; // Number of temperature channels

  typedef struct packed {
    tmr_frz_t frz; // Freeze machine
    logic [NCH-1:0] pend; // Result bytes still to be read while frozen
    logic [NCH-1:0][9:0] shadow; // Latest formatted result per channel
    logic [NCH-1:0][7:0] value; // Host-visible result bytes
    logic [7:0] low_bits; // Host-visible low-bits register
    logic [NCH-1:0][7:0] low_lim; // Low limits
    logic [NCH-1:0][7:0] high_lim; // High limits
    logic [NCH-1:0][7:0] offset; // Offset registers
    logic [7:0] cfg5; // Configuration register five
    logic [7:0] rdata; // Read data holding register
    logic [NCH-1:0] hi_st; // High status
    logic [NCH-1:0] lo_st; // Low status
  } tmr_state_t;

  tmr_state_t st; // Registered state
  tmr_state_t next_st; // Next state

  // ----------------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------------
  // Result byte offset to channel index; hit flag in bit 2
  function automatic logic [2:0] value_sel(input logic [7:0] a);
    value_sel = 3'h0;
    if (a == TMR_REMOTE1_TEMP_VALUE) value_sel = 3'h4;
    else if (a == TMR_LOCAL_TEMP_VALUE) value_sel = 3'h5;
    else if (a == TMR_REMOTE2_TEMP_VALUE) value_sel = 3'h6;
  endfunction : value_sel

  // Limit offset to {hit, is_high, channel}
  function automatic logic [3:0] limit_sel(input logic [7:0] a);
    limit_sel = 4'h0;
    if (a == TMR_REMOTE1_TEMP_LOW_LIMIT) limit_sel = 4'h8;
    else if (a == TMR_REMOTE1_TEMP_HIGH_LIMIT) limit_sel = 4'hC;
    else if (a == TMR_LOCAL_TEMP_LOW_LIMIT) limit_sel = 4'h9;
    else if (a == TMR_LOCAL_TEMP_HIGH_LIMIT) limit_sel = 4'hD;
    else if (a == TMR_REMOTE2_TEMP_LOW_LIMIT) limit_sel = 4'hA;
    else if (a == TMR_REMOTE2_TEMP_HIGH_LIMIT) limit_sel = 4'hE;
  endfunction : limit_sel

  // Offset register address to {hit, channel}
  function automatic logic [2:0] offset_sel(input logic [7:0] a);
    offset_sel = 3'h0;
    if (a == TMR_REMOTE1_TEMP_OFFSET) offset_sel = 3'h4;
    else if (a == TMR_LOCAL_TEMP_OFFSET) offset_sel = 3'h5;
    else if (a == TMR_REMOTE2_TEMP_OFFSET) offset_sel = 3'h6;
  endfunction : offset_sel

  // ----------------------------------------------------------------------
  // Formatter: one shared instance, since the converter delivers one
  // channel at a time
  // ----------------------------------------------------------------------
  tmr_fmt_if fbus ();
  logic chan_ok; // Measurement channel is one of the three
  logic [1:0] chan_idx; // Safe index into per-channel arrays
  logic compat; // Compatibility bit

  assign compat = st.cfg5[TMR_COMPAT_BIT];
  assign chan_ok = (meas_chan == TMR_CH_REMOTE1) || (meas_chan == TMR_CH_LOCAL) ||
                   (meas_chan == TMR_CH_REMOTE2);
  assign chan_idx = chan_ok ? meas_chan : 2'h0;
  assign fbus.raw = meas_temp;
  assign fbus.fault = meas_fault;
  assign fbus.offset = st.offset[chan_idx];
  assign fbus.compat = compat;

  tmr_fmt u_fmt (
    .f (fbus.fmt)
  );

  // ----------------------------------------------------------------------
  // Limit comparators, one per channel, on the latest stored result
  // ----------------------------------------------------------------------
  logic [NCH-1:0] above; // Result above high limit
  logic [NCH-1:0] below; // Result at or below low limit

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_cmp
      tmr_cmp u_cmp (
        .value (st.shadow[gi][9:2]),
        .low_limit (st.low_lim[gi]),
        .high_limit (st.high_lim[gi]),
        .compat (compat),
        .above (above[gi]),
        .below (below[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  logic [2:0] rd_val; // Read decode of result bytes
  logic [3:0] wr_lim; // Write decode of limits
  logic [2:0] wr_off; // Write decode of offsets
  logic [7:0] lim_wdata; // Limit write data after clamping
  logic [NCH-1:0] pend_left; // Pending set after this cycle's read
  logic [7:0] live_low_bits; // Low bits built from the shadow copies

  always_comb begin
    next_st = st;
    rd_val = value_sel(reg_addr);
    wr_lim = limit_sel(reg_addr);
    wr_off = offset_sel(reg_addr);
    pend_left = st.pend;
    lim_wdata = reg_wdata;

    // Pack the low-order pairs of all three channels
    live_low_bits = TMR_LOW_BITS_RST;
    live_low_bits[TMR_REMOTE1_LOW_BITS_POS +: 2] = st.shadow[TMR_CH_REMOTE1][1:0];
    live_low_bits[TMR_LOCAL_LOW_BITS_POS +: 2] = st.shadow[TMR_CH_LOCAL][1:0];
    live_low_bits[TMR_REMOTE2_LOW_BITS_POS +: 2] = st.shadow[TMR_CH_REMOTE2][1:0];

    // New measurement always lands in the shadow, frozen or not, so
    // nothing is lost; only the host view is held
    if (meas_valid && chan_ok) begin
      next_st.shadow[chan_idx] = fbus.code;
    end

    // Status follows the latest stored result of each channel
    next_st.hi_st = above;
    next_st.lo_st = below;

    // Register writes; read-only and unmapped offsets ignore writes
    if (reg_wr) begin
      // In compatibility mode limits below -63 are raised to -63
      if (compat && ($signed(reg_wdata) < TMR_LIMIT_FLOOR)) begin
        lim_wdata = TMR_LIMIT_FLOOR;
      end
      if (wr_lim[3]) begin
        // Limit write
        if (wr_lim[2]) next_st.high_lim[wr_lim[1:0]] = lim_wdata;
        else next_st.low_lim[wr_lim[1:0]] = lim_wdata;
      end else if (wr_off[2]) begin
        // Offset write
        next_st.offset[wr_off[1:0]] = reg_wdata;
      end else if (reg_addr == TMR_CONFIG5) begin
        // Only the compatibility bit is implemented here
        next_st.cfg5 = TMR_CONFIG5_RST;
        next_st.cfg5[TMR_COMPAT_BIT] = reg_wdata[TMR_COMPAT_BIT];
      end
    end

    // Register reads; data registered for the next cycle
    next_st.rdata = 8'h00;
    if (reg_rd) begin
      if (rd_val[2]) begin
        // Result bytes read freely; only a frozen read has an effect
        next_st.rdata = st.value[rd_val[1:0]];
        pend_left[rd_val[1:0]] = 1'b0;
      end else if (wr_lim[3]) begin
        next_st.rdata = wr_lim[2] ? st.high_lim[wr_lim[1:0]] : st.low_lim[wr_lim[1:0]];
      end else if (wr_off[2]) begin
        next_st.rdata = st.offset[wr_off[1:0]];
      end else if (reg_addr == TMR_TEMP_LOW_BITS) begin
        next_st.rdata = st.low_bits;
      end else if (reg_addr == TMR_CONFIG5) begin
        next_st.rdata = st.cfg5;
      end
    end

    // Freeze machine
    unique case (st.frz)
      TMR_LIVE: begin
        // Host view tracks the shadow copies
        for (int i = 0; i < NCH; i++) begin
          next_st.value[i] = st.shadow[i][9:2];
        end
        next_st.low_bits = live_low_bits;
        next_st.pend = '0;
        if (reg_rd && (reg_addr == TMR_TEMP_LOW_BITS)) begin
          // Low bits taken: hold every result byte until each is read
          next_st.frz = TMR_FROZEN;
          next_st.pend = '1;
          next_st.value = st.value;
          next_st.low_bits = st.low_bits;
        end
      end
      TMR_FROZEN: begin
        // Host view held; shadow keeps collecting
        if (reg_rd && (reg_addr == TMR_TEMP_LOW_BITS)) begin
          // A repeated low-bits read starts the set over
          next_st.pend = '1;
        end else if (pend_left == '0) begin
          next_st.frz = TMR_LIVE;
          next_st.pend = '0;
        end else begin
          next_st.pend = pend_left;
        end
      end
      default: begin
        // Illegal code: recover to live tracking
        next_st.frz = TMR_LIVE;
        next_st.pend = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register with synchronous reset
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st.frz <= TMR_LIVE;
      st.pend <= '0;
      for (int i = 0; i < NCH; i++) begin
        // Shadow starts at the reset result so the host view matches
        st.shadow[i] <= {TMR_VALUE_RST, 2'b00};
        st.value[i] <= TMR_VALUE_RST;
        st.low_lim[i] <= TMR_LOW_LIMIT_RST;
        st.high_lim[i] <= TMR_HIGH_LIMIT_RST;
        st.offset[i] <= TMR_OFFSET_RST;
      end
      st.low_bits <= TMR_LOW_BITS_RST;
      st.cfg5 <= TMR_CONFIG5_RST;
      st.rdata <= 8'h00;
      st.hi_st <= '0;
      st.lo_st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign temp_high_status = st.hi_st;
  assign temp_low_status = st.lo_st;
  // Level request toward the alert logic outside this block
  assign alert_req = |{st.hi_st, st.lo_st};
  assign result_frozen = (st.frz == TMR_FROZEN);
  assign compat_mode = compat;

endmodule : tmr_top

// File: design/tmr_pkg.sv
// Shared constants and types for the temperature result register block
package tmr_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] TMR_REMOTE1_TEMP_VALUE = 8'h25;
  localparam logic [7:0] TMR_LOCAL_TEMP_VALUE = 8'h26;
  localparam logic [7:0] TMR_REMOTE2_TEMP_VALUE = 8'h27;
  localparam logic [7:0] TMR_REMOTE1_TEMP_LOW_LIMIT = 8'h4E;
  localparam logic [7:0] TMR_REMOTE1_TEMP_HIGH_LIMIT = 8'h4F;
  localparam logic [7:0] TMR_LOCAL_TEMP_LOW_LIMIT = 8'h50;
  localparam logic [7:0] TMR_LOCAL_TEMP_HIGH_LIMIT = 8'h51;
  localparam logic [7:0] TMR_REMOTE2_TEMP_LOW_LIMIT = 8'h52;
  localparam logic [7:0] TMR_REMOTE2_TEMP_HIGH_LIMIT = 8'h53;
  localparam logic [7:0] TMR_REMOTE1_TEMP_OFFSET = 8'h70;
  localparam logic [7:0] TMR_LOCAL_TEMP_OFFSET = 8'h71;
  localparam logic [7:0] TMR_REMOTE2_TEMP_OFFSET = 8'h72;
  localparam logic [7:0] TMR_TEMP_LOW_BITS = 8'h77;
  localparam logic [7:0] TMR_CONFIG5 = 8'h7C;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int TMR_COMPAT_BIT = 1;
  localparam int TMR_REMOTE1_LOW_BITS_POS = 2;
  localparam int TMR_LOCAL_LOW_BITS_POS = 4;
  localparam int TMR_REMOTE2_LOW_BITS_POS = 6;
  localparam logic [7:0] TMR_VALUE_RST = 8'h01;
  localparam logic [7:0] TMR_LOW_BITS_RST = 8'h00;
  localparam logic [7:0] TMR_LOW_LIMIT_RST = 8'h01;
  localparam logic [7:0] TMR_HIGH_LIMIT_RST = 8'h7F;
  localparam logic [7:0] TMR_OFFSET_RST = 8'h00;
  localparam logic [7:0] TMR_CONFIG5_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Encodings, in quarter degrees where 13 bits wide
  // ----------------------------------------------------------------------
  localparam logic signed [12:0] TMR_TWOS_MIN = 13'sh1E00;
  localparam logic signed [12:0] TMR_TWOS_MAX = 13'sh1FF;
  localparam logic signed [12:0] TMR_EXT_MIN = 13'sh1F00;
  localparam logic signed [12:0] TMR_EXT_MAX = 13'sh2FF;
  localparam logic signed [12:0] TMR_EXT_BIAS = 13'sh100;
  localparam logic [7:0] TMR_FAULT_TWOS = 8'h80;
  localparam logic [7:0] TMR_FAULT_EXT = 8'h00;
  localparam logic signed [7:0] TMR_LIMIT_FLOOR = 8'shC1;

  // ----------------------------------------------------------------------
  // Channels and freeze states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TMR_CH_REMOTE1 = 2'h0,
    TMR_CH_LOCAL = 2'h1,
    TMR_CH_REMOTE2 = 2'h2
  } tmr_chan_t;

  typedef enum logic [1:0] {
    TMR_LIVE = 2'b01,
    TMR_FROZEN = 2'b10
  } tmr_frz_t;

endpackage : tmr_pkg

// File: design/tmr_fmt_if.sv
// Carrier between the core and the result formatter
`timescale 1ns/100ps
interface tmr_fmt_if;
  logic signed [11:0] raw; // Raw measurement, quarter degrees, twos complement
  logic fault; // Diode fault seen on this measurement
  logic [7:0] offset; // Channel offset, half degree per count
  logic compat; // Twos complement storage selected
  logic [9:0] code; // Stored 10-bit result code
  modport fmt (input raw, input fault, input offset, input compat, output code);
  modport core (output raw, output fault, output offset, output compat, input code);
endinterface : tmr_fmt_if

// File: design/tmr_fmt.sv
// Offset correction, saturation and encoding of one measurement
`timescale 1ns/100ps
module tmr_fmt
  import tmr_pkg::*;
(
  tmr_fmt_if.fmt f
);
  // ----------------------------------------------------------------------
  // Correct, clamp, encode
  // ----------------------------------------------------------------------
  logic signed [12:0] sum; // Corrected value, quarter degrees
  logic signed [12:0] sat; // Saturated value
  logic signed [12:0] biased; // Offset-64 view of the saturated value

  always_comb begin
    // Offset count is half a degree, i.e. two quarter steps
    sum = {f.raw[11], f.raw} + {{4{f.offset[7]}}, f.offset, 1'b0};
    sat = sum;
    if (f.compat) begin
      // Clamp into -128 .. +127.75 rather than wrap
      if (sum < TMR_TWOS_MIN) sat = TMR_TWOS_MIN;
      else if (sum > TMR_TWOS_MAX) sat = TMR_TWOS_MAX;
    end else begin
      // Clamp into -64 .. +191.75
      if (sum < TMR_EXT_MIN) sat = TMR_EXT_MIN;
      else if (sum > TMR_EXT_MAX) sat = TMR_EXT_MAX;
    end
    biased = sat + TMR_EXT_BIAS;
    if (f.fault) begin
      // Fault code depends on the active encoding
      f.code = {(f.compat ? TMR_FAULT_TWOS : TMR_FAULT_EXT), 2'b00};
    end else if (f.compat) begin
      f.code = sat[9:0];
    end else begin
      f.code = biased[9:0];
    end
  end
endmodule : tmr_fmt

// File: design/tmr_cmp.sv
// Window comparison of one result against its limits
`timescale 1ns/100ps
module tmr_cmp (
  input wire logic [7:0] value,
  input wire logic [7:0] low_limit,
  input wire logic [7:0] high_limit,
  input wire logic compat,
  output logic above,
  output logic below
);
  // ----------------------------------------------------------------------
  // Flip the sign bit in signed mode so one unsigned compare serves both
  // ----------------------------------------------------------------------
  logic [7:0] v_key; // Ordered key of the result
  logic [7:0] l_key; // Ordered key of the low limit
  logic [7:0] h_key; // Ordered key of the high limit

  always_comb begin
    v_key = {value[7] ^ compat, value[6:0]};
    l_key = {low_limit[7] ^ compat, low_limit[6:0]};
    h_key = {high_limit[7] ^ compat, high_limit[6:0]};
    above = v_key > h_key;
    below = v_key <= l_key;
  end
endmodule : tmr_cmp

// File: dv/tmr_asserts.sv
// Concurrent checks on the ports of the temperature result register block
`timescale 1ns/100ps
module tmr_asserts
  import tmr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] temp_high_status,
  input wire logic [2:0] temp_low_status,
  input wire logic alert_req,
  input wire logic result_frozen,
  input wire logic compat_mode
);
  // ----------------------------------------------------------------------
  // Clocking and named steps
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Host read of the low-bits register, the first step of a 10-bit read
  sequence s_low_read;
    reg_rd && reg_addr == TMR_TEMP_LOW_BITS;
  endsequence
  // Limit write below the floor while twos complement storage is active
  sequence s_clamp_wr;
    compat_mode && reg_wr && !reg_rd && reg_addr == TMR_REMOTE1_TEMP_LOW_LIMIT
      && $signed(reg_wdata) < 8'shC1;
  endsequence
  // Read back of that same limit, one idle cycle later
  sequence s_limit_rd;
    reg_rd && !reg_wr && reg_addr == TMR_REMOTE1_TEMP_LOW_LIMIT;
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_RESET_OUTPUTS: assert property ($rose(rst_n) |-> reg_rdata == 8'h00
    && !result_frozen && !compat_mode && !alert_req)
    else $error("outputs not cleared by reset");
  AST_ALERT_OR: assert property (alert_req == (|temp_high_status || |temp_low_status))
    else $error("alert request differs from status bits");
  AST_FREEZE_ON_LOW_READ: assert property (s_low_read |=> result_frozen)
    else $error("low-bits read did not freeze results");
  AST_FREEZE_HOLDS: assert property (result_frozen && !reg_rd |=> result_frozen)
    else $error("freeze released without a read");
  AST_LIVE_READ_NO_FREEZE: assert property (!result_frozen && reg_rd
    && reg_addr inside {[8'h25:8'h27]} |=> !result_frozen)
    else $error("result byte read changed freeze state");
  AST_COMPAT_WRITE: assert property (reg_wr && reg_addr == TMR_CONFIG5
    |=> compat_mode == $past(reg_wdata[TMR_COMPAT_BIT]))
    else $error("compat mode does not follow config write");
  AST_COMPAT_STABLE: assert property (!(reg_wr && reg_addr == TMR_CONFIG5)
    |=> $stable(compat_mode))
    else $error("compat mode changed without a write");
  AST_CONFIG_READ: assert property (reg_rd && !reg_wr && reg_addr == TMR_CONFIG5
    |=> reg_rdata == {6'h00, compat_mode, 1'b0})
    else $error("config read value wrong");
  AST_LIMIT_CLAMP: assert property (s_clamp_wr ##1 !reg_wr ##1 s_limit_rd
    |=> reg_rdata == 8'hC1)
    else $error("low limit not clamped");
endmodule : tmr_asserts

bind tmr_top tmr_asserts u_ast (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .temp_high_status(temp_high_status), .temp_low_status(temp_low_status),
  .alert_req(alert_req), .result_frozen(result_frozen), .compat_mode(compat_mode));

// File: dv/tmr_host.sv
// Management host model that drives the register strobes
`timescale 1ns/100ps
module tmr_host (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write; address and data flip after release so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // One read strobe; the bench notes the expected answer
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : tmr_host

// File: dv/tmr_top_tb.sv
// Self-checking bench for the temperature result register block
`timescale 1ns/100ps
module tmr_top_tb
  import tmr_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, alert_req, result_frozen, compat_mode;
  logic meas_valid = 1'b0;
  logic [1:0] meas_chan = 2'h0;
  logic signed [11:0] meas_temp = 12'sh000;
  logic meas_fault = 1'b0;
  logic [2:0] hi_st, lo_st;
  int failures = 0;
  int total_checks = 0;
  int seed = 47;
  logic [7:0] exp_q[$]; // Expected read answers, oldest first
  logic rd_seen = 1'b0; // A read was taken at the previous edge
  logic [9:0] code_e [3] = '{10'h004, 10'h004, 10'h004}; // Stored codes, reset 0x01 / 00
  logic [7:0] ra [15] = '{8'h25, 8'h26, 8'h27, 8'h77, 8'h4E, 8'h4F, 8'h50, 8'h51, 8'h52,
    8'h53, 8'h70, 8'h71, 8'h72, 8'h7C, 8'h10};
  logic [7:0] rv [15] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h01, 8'h7F, 8'h01, 8'h7F, 8'h01,
    8'h7F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  always #25 core_clk = ~core_clk;

  tmr_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .meas_chan(meas_chan), .meas_temp(meas_temp), .meas_fault(meas_fault),
    .temp_high_status(hi_st), .temp_low_status(lo_st), .alert_req(alert_req),
    .result_frozen(result_frozen), .compat_mode(compat_mode));
  tmr_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));

  // ----------------------------------------------------------------------
  // Comparison, expectation and end of run
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Read data stands only in the cycle after the strobe, so it is taken there
  always @(posedge core_clk) begin
    if (rd_seen) check(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end
  // Expected code with offset, saturation and fault substitution
  function automatic logic [9:0] ecode(input logic signed [11:0] t, input logic [7:0] o,
    input logic cm, input logic f);
    int s;
    s = int'(t) + 2 * int'($signed(o));
    if (f) return cm ? 10'h200 : 10'h000;
    if (cm) return (s > 511) ? 10'h1FF : (s < -512) ? 10'h200 : s[9:0];
    s = s + 256;
    return (s > 1023) ? 10'h3FF : (s < 0) ? 10'h000 : s[9:0];
  endfunction : ecode
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask : rd_chk
  // Low bits first when with_low is set, then every result byte, which lifts the freeze
  task automatic read_all(input logic with_low);
    if (with_low) rd_chk(TMR_TEMP_LOW_BITS, {code_e[2][1:0], code_e[1][1:0],
      code_e[0][1:0], 2'b00});
    for (int k = 0; k < 3; k++) rd_chk(8'(TMR_REMOTE1_TEMP_VALUE + k), code_e[k][9:2]);
    check({7'h00, result_frozen}, 8'h00);
  endtask : read_all
  // One measurement, then a dummy on channel 3 that must be ignored
  task automatic pulse(input logic [1:0] ch, input logic signed [11:0] t, input logic f);
    @(posedge core_clk);
    #1;
    meas_valid = 1'b1;
    meas_chan = ch;
    meas_temp = t;
    meas_fault = f;
    @(posedge core_clk);
    #1;
    meas_chan = 2'h3;
    meas_temp = ~t;
    meas_fault = ~f;
    @(posedge core_clk);
    #1;
    meas_valid = 1'b0;
  endtask : pulse
  // Full pass on one channel: mode, offset, measure, limits, status, readback
  task automatic one_meas(input logic cm, input logic [1:0] ch, input logic signed [11:0] t,
    input logic [7:0] off, input logic f, input logic [1:0] sel);
    logic [7:0] vb, hl, ll;
    host.wr(TMR_CONFIG5, {6'h00, cm, 1'b0});
    host.wr(8'(TMR_REMOTE1_TEMP_OFFSET + ch), off);
    pulse(ch, t, f);
    code_e[ch] = ecode(t, off, cm, f);
    vb = code_e[ch][9:2];
    hl = sel[0] ? vb : 8'($random(seed));
    ll = sel[1] ? vb : 8'($random(seed));
    host.wr(8'(TMR_REMOTE1_TEMP_HIGH_LIMIT + 2 * ch), hl);
    host.wr(8'(TMR_REMOTE1_TEMP_LOW_LIMIT + 2 * ch), ll);
    if (cm && $signed(hl) < -63) hl = 8'hC1;
    if (cm && $signed(ll) < -63) ll = 8'hC1;
    repeat (3) @(posedge core_clk);
    #1;
    check({7'h00, hi_st[ch]}, {7'h00, cm ? $signed(vb) > $signed(hl) : vb > hl});
    check({7'h00, lo_st[ch]}, {7'h00, cm ? $signed(vb) <= $signed(ll) : vb <= ll});
    read_all(1'b1);
    rd_chk(8'(TMR_REMOTE1_TEMP_LOW_LIMIT + 2 * ch), ll);
  endtask : one_meas

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 15; i++) rd_chk(ra[i], rv[i]);
    check({4'h0, alert_req, lo_st}, 8'h0F);
    $display("test reset values done");
    host.wr(TMR_REMOTE1_TEMP_VALUE, 8'hAA);
    host.wr(TMR_TEMP_LOW_BITS, 8'hFF);
    host.wr(8'h10, 8'h5A);
    read_all(1'b1);
    rd_chk(8'h10, 8'h00);
    host.wr(TMR_CONFIG5, 8'hFF);
    rd_chk(TMR_CONFIG5, 8'h02);
    check({7'h00, compat_mode}, 8'h01);
    $display("test read-only and config done");
    for (int i = 0; i < 12; i++) one_meas(1'b0, 2'(i % 3), 12'($random(seed)),
      8'($random(seed)), 1'b0, 2'(i));
    $display("test random measurements done");
    one_meas(1'b0, 2'h2, 12'sh7FF, 8'h7F, 1'b0, 2'h0);
    one_meas(1'b0, 2'h1, 12'sh800, 8'h80, 1'b0, 2'h3);
    one_meas(1'b0, 2'h0, 12'sh064, 8'h00, 1'b1, 2'h0);
    one_meas(1'b1, 2'h1, 12'shE70, 8'h06, 1'b0, 2'h1);
    one_meas(1'b1, 2'h2, 12'sh7D0, 8'h7F, 1'b0, 2'h2);
    one_meas(1'b1, 2'h0, 12'sh800, 8'h80, 1'b0, 2'h0);
    one_meas(1'b1, 2'h1, 12'sh000, 8'h00, 1'b1, 2'h3);
    host.wr(TMR_REMOTE1_TEMP_LOW_LIMIT, 8'h80);
    rd_chk(TMR_REMOTE1_TEMP_LOW_LIMIT, 8'hC1);
    $display("test edge cases done");
    host.wr(TMR_CONFIG5, 8'h00);
    host.wr(TMR_REMOTE1_TEMP_OFFSET, 8'h00);
    rd_chk(TMR_TEMP_LOW_BITS, {code_e[2][1:0], code_e[1][1:0],
      code_e[0][1:0], 2'b00});
    check({7'h00, result_frozen}, 8'h01);
    pulse(2'h0, 12'sh065, 1'b0);
    repeat (3) @(posedge core_clk);
    read_all(1'b0);
    code_e[0] = ecode(12'sh065, 8'h00, 1'b0, 1'b0);
    repeat (2) @(posedge core_clk);
    read_all(1'b1);
    $display("test freeze done");
    repeat (4) @(posedge core_clk);
    complete_run();
  end
  // Watchdog, far beyond the expected run of a few hundred cycles
  initial begin
    #(20000 * 50);
    failures++;
    complete_run();
  end
endmodule : tmr_top_tb
